// file: hw/pfag_pkg.sv
package pfag_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int PIN_COUNT     = 8;
  localparam int ANALOG_PINS   = 7;
  localparam int FIRST_CHANNEL = 5;
  localparam int PIN_C2_OUT    = 1;
  localparam int PIN_C1_OUT    = 2;
  localparam int PIN_CMP_LO    = 3;
  localparam int PIN_CMP_HI    = 6;
  localparam int PIN_REF       = 5;
  localparam int PIN_SELECT    = 7;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIRECTION = 8'h00;
  localparam logic [7:0] OFS_LEVEL     = 8'h04;
  localparam logic [7:0] OFS_LATCH     = 8'h08;
  localparam logic [7:0] OFS_ANALOG    = 8'h0C;
  localparam logic [7:0] OFS_COMPARE   = 8'h10;
  localparam logic [7:0] OFS_REFOUT    = 8'h14;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int         PCFG_LSB     = 0;
  localparam int         VCFG_LSB     = 4;
  localparam logic [4:0] PCFG_LIMIT   = 5'h0E;
  localparam int         CM_LSB       = 0;
  localparam int         SWITCH_BIT   = 3;
  localparam int         INV_ONE_BIT  = 4;
  localparam int         INV_TWO_BIT  = 5;
  localparam int         RES_ONE_BIT  = 6;
  localparam int         RES_TWO_BIT  = 7;
  localparam logic [2:0] CM_OFF       = 3'h7;
  localparam logic [2:0] CM_BOTH_OUT  = 3'h3;
  localparam logic [2:0] CM_TWO_OUT   = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RESET    = 8'hFF;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [5:0] ANALOG_RESET = 6'h00;
  localparam logic [5:0] CMP_RESET    = 6'h07;
  localparam logic [6:0] MASK_RESET   = 7'h7F;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pfag_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pfag_wb_rsp_type;

  typedef struct packed {
    logic dir;
    logic latch;
    logic alt_en;
    logic alt_val;
    logic analog;
    logic kill;
  } pfag_pin_ctrl_type;

  typedef enum logic {BUS_IDLE, BUS_ACK} pfag_bus_state_type;

endpackage

// file: hw/pfag_channel_decode.sv
`timescale 1ns/1ps
module pfag_channel_decode
  import pfag_pkg::*;
#(
  parameter int PINS  = ANALOG_PINS,
  parameter int FIRST = FIRST_CHANNEL
) (
  // Configuration
  input  wire logic [3:0]      pcfg_i,
  // Analog selection
  output logic      [PINS-1:0] analog_o
);

  if (PINS < 1 || FIRST + PINS > 15) begin : g_check
    $error("pfag_channel_decode: channel range out of reach");
  end

  // Lower channels stay analog longest; all-ones code frees every pin
  always_comb begin
    for (int p = 0; p < PINS; p++) begin
      analog_o[p] = (5'({1'b0, pcfg_i}) + 5'(FIRST + p)) <= PCFG_LIMIT;
    end
  end

endmodule

// file: hw/pfag_pin_cell.sv
`timescale 1ns/1ps
module pfag_pin_cell
  import pfag_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire pfag_pin_ctrl_type ctrl_i,
  // Pad
  input  wire logic              pad_i,
  output logic                   pad_o,
  output logic                   pad_oe_o,
  // Sampled level
  output logic                   level_o
);

  typedef struct packed {
    logic out;
    logic oe;
    logic level;
  } pfag_cell_state_type;

  pfag_cell_state_type state_ff;
  pfag_cell_state_type nxt_state;

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.oe    = !ctrl_i.dir && !ctrl_i.kill;                    // [R12] [R7] [R11]
    nxt_state.out   = ctrl_i.alt_en ? ctrl_i.alt_val : ctrl_i.latch;  // [R1] [R5] [R6]
    // Input buffer gated off so an analog level never toggles logic
    nxt_state.level = pad_i && !ctrl_i.analog && !ctrl_i.kill;        // [R2] [R7] [R14]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pad_o    = state_ff.out;
  assign pad_oe_o = state_ff.oe;
  assign level_o  = state_ff.level;

endmodule

// file: hw/pfag_port.sv
// The address map and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1: Output pin drives its latch bit; analog enable leaves that drive alone.
// R2: Input pin is sampled digitally, but reads zero while its analog input is on.
// R3: Reset makes pins 0..2 analog channels five to seven, direction input.
// R4: Reset makes pins 3..6 analog channels eight to eleven, also comparator inputs.
// R5: Comparator two result overrides the latch on output pin 1 when routed.
// R6: Comparator one result overrides the latch on output pin 2 when routed.
// R7: Reference output on pin 5 kills its driver and input path.
// R8: Pin 7 is digital only; as input it feeds the serial slave select.
// R9: Analog config bits 7:6 read zero; 5:4 reference select, 3:0 pin config.
// R10: Software writes 0x0F to analog config before trusting digital reads.
// R11: Each direction bit steers its own pin; one means input.
// R12: Direction one floats the driver; zero drives the latch onto the pin.
// R13: Latch register reads back the latch, not the pin levels.
// R14: After reset pins 6:0 are analog and read as zero.
// R15: Comparator mode bits decide whether pins 1 and 2 carry comparator outputs.
// R16: Level address writes go to the latch; reads return sampled pin levels.
// R17: Direction, latch and level registers are eight bits, bit n is pin n.
module pfag_port
  import pfag_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register bus
  input  wire pfag_wb_req_type        wb_req_i,
  output pfag_wb_rsp_type             wb_rsp_o,
  // Port pins
  input  wire logic [PIN_COUNT-1:0]   pin_in_i,
  output logic      [PIN_COUNT-1:0]   pin_out_o,
  output logic      [PIN_COUNT-1:0]   pin_oe_o,
  // Comparator results before inversion
  input  wire logic                   comparator_one_raw_i,
  input  wire logic                   comparator_two_raw_i,
  // Analog side controls
  output logic      [ANALOG_PINS-1:0] analog_enable_o,
  output logic      [1:0]             vref_select_o,
  output logic      [2:0]             comparator_mode_o,
  output logic                        comparator_input_switch_o,
  output logic                        comparator_reference_output_o,
  // Serial slave select
  output logic                        serial_slave_select_one_n_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pfag_bus_state_type     bus;
    logic                   ack;
    logic [7:0]             rdat;
    logic [PIN_COUNT-1:0]   dir;
    logic [PIN_COUNT-1:0]   latch;
    logic [5:0]             analog_cfg;
    logic [5:0]             cmp_cfg;
    logic                   refout;
    logic                   c1_res;
    logic                   c2_res;
    logic [ANALOG_PINS-1:0] mask;
    logic                   ss_n;
  } pfag_state_type;

  pfag_state_type state_ff;
  pfag_state_type nxt_state;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Register map holds one bit per pin in a single byte lane
  if (PIN_COUNT != 8) begin : g_chk_width
    $error("pfag_port: pin count must fill one byte lane");
  end
  // Digital-only select pin must sit above every analog pin
  if (ANALOG_PINS >= PIN_COUNT || PIN_SELECT < ANALOG_PINS) begin : g_chk_analog
    $error("pfag_port: analog pins overlap the select pin");
  end
  // Comparator inputs and reference output live on analog pins
  if (PIN_CMP_LO > PIN_CMP_HI || PIN_CMP_HI >= ANALOG_PINS) begin : g_chk_cmp
    $error("pfag_port: comparator input pins out of range");
  end
  if (PIN_REF >= ANALOG_PINS) begin : g_chk_ref
    $error("pfag_port: reference output pin out of range");
  end
  // Result pins take the comparator override in the pin cell
  if (PIN_C1_OUT >= ANALOG_PINS || PIN_C2_OUT >= ANALOG_PINS) begin : g_chk_res
    $error("pfag_port: comparator result pins out of range");
  end

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  logic [ANALOG_PINS-1:0] decode_mask;
  logic [ANALOG_PINS-1:0] cmp_mask;
  logic [PIN_COUNT-1:0]   level;
  logic [2:0]             cmp_mode;
  logic                   route_c1;
  logic                   route_c2;
  logic                   cmp_on;
  logic                   wr_hit;
  logic [7:0]             wdat;
  logic [7:0]             rd_value;
  logic [7:0]             analog_read;
  logic [7:0]             cmp_read;
  pfag_pin_ctrl_type      ctrl [PIN_COUNT];

  assign cmp_mode = state_ff.cmp_cfg[CM_LSB +: 3];
  assign cmp_on   = cmp_mode != CM_OFF;
  assign route_c2 = (cmp_mode == CM_BOTH_OUT) || (cmp_mode == CM_TWO_OUT);  // [R15]
  assign route_c1 = cmp_mode == CM_BOTH_OUT;                                // [R15]

  pfag_channel_decode #(
    .PINS  (ANALOG_PINS),
    .FIRST (FIRST_CHANNEL)
  ) u_decode (
    .pcfg_i   (state_ff.analog_cfg[PCFG_LSB +: 4]),
    .analog_o (decode_mask)
  );

  // Comparator inputs claim pins 3..6 whenever a comparator runs
  always_comb begin
    cmp_mask = '0;
    for (int p = PIN_CMP_LO; p <= PIN_CMP_HI; p++) begin
      cmp_mask[p] = cmp_on;  // [R4]
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      ctrl[p].dir     = state_ff.dir[p];  // [R11] [R17]
      ctrl[p].latch   = state_ff.latch[p];
      ctrl[p].alt_en  = 1'b0;
      ctrl[p].alt_val = 1'b0;
      ctrl[p].analog  = 1'b0;
      ctrl[p].kill    = 1'b0;
    end
    for (int p = 0; p < ANALOG_PINS; p++) begin
      ctrl[p].analog = state_ff.mask[p];  // [R3] [R4] [R14]
    end
    // Pin 7 keeps analog low: it has no analog function
    ctrl[PIN_C2_OUT].alt_en  = route_c2;         // [R5]
    ctrl[PIN_C2_OUT].alt_val = state_ff.c2_res;  // [R5]
    ctrl[PIN_C1_OUT].alt_en  = route_c1;         // [R6]
    ctrl[PIN_C1_OUT].alt_val = state_ff.c1_res;  // [R6]
    ctrl[PIN_REF].kill       = state_ff.refout;  // [R7]
  end

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pfag_pin_cell u_cell (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ctrl_i   (ctrl[g]),
      .pad_i    (pin_in_i[g]),
      .pad_o    (pin_out_o[g]),
      .pad_oe_o (pin_oe_o[g]),
      .level_o  (level[g])
    );
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    analog_read = {2'b00, state_ff.analog_cfg};  // [R9]
    cmp_read    = {state_ff.c2_res, state_ff.c1_res, state_ff.cmp_cfg};
    case (wb_req_i.adr)
      OFS_DIRECTION: begin
        rd_value = state_ff.dir;
      end
      OFS_LEVEL: begin
        rd_value = level;  // [R16] [R2] [R14]
      end
      OFS_LATCH: begin
        rd_value = state_ff.latch;  // [R13]
      end
      OFS_ANALOG: begin
        rd_value = analog_read;
      end
      OFS_COMPARE: begin
        rd_value = cmp_read;
      end
      OFS_REFOUT: begin
        rd_value = {7'h00, state_ff.refout};
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus and register update
  // ----------------------------------------------------------------
  // Writes land on the edge where the master sees ack, never earlier
  assign wr_hit = (state_ff.bus == BUS_ACK) && wb_req_i.cyc && wb_req_i.stb
                  && wb_req_i.we && wb_req_i.sel[0];
  assign wdat   = wb_req_i.dat[7:0];

  always_comb begin
    nxt_state = state_ff;
    case (state_ff.bus)
      BUS_IDLE: begin
        if (wb_req_i.cyc && wb_req_i.stb) begin
          nxt_state.ack  = 1'b1;
          nxt_state.rdat = rd_value;
          nxt_state.bus  = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_state.ack = 1'b0;
        nxt_state.bus = BUS_IDLE;
      end
      default: begin
        nxt_state.ack = 1'b0;
        nxt_state.bus = BUS_IDLE;
      end
    endcase

    if (wr_hit) begin
      case (wb_req_i.adr)
        OFS_DIRECTION: begin
          nxt_state.dir = wdat;  // [R11] [R17]
        end
        OFS_LEVEL, OFS_LATCH: begin
          nxt_state.latch = wdat;  // [R16] [R13]
        end
        OFS_ANALOG: begin
          nxt_state.analog_cfg = wdat[5:0];  // [R9] [R10]
        end
        OFS_COMPARE: begin
          nxt_state.cmp_cfg = wdat[5:0];  // [R15]
        end
        OFS_REFOUT: begin
          nxt_state.refout = wdat[0];  // [R7]
        end
        default: begin
          nxt_state.refout = state_ff.refout;
        end
      endcase
    end

    // Comparator result, inverted when its invert bit is set, one cycle behind the raw input
    nxt_state.c1_res = comparator_one_raw_i ^ state_ff.cmp_cfg[INV_ONE_BIT];
    nxt_state.c2_res = comparator_two_raw_i ^ state_ff.cmp_cfg[INV_TWO_BIT];
    nxt_state.mask   = decode_mask | cmp_mask;  // [R2] [R4]
    // Inactive high whenever pin 7 is not an input
    nxt_state.ss_n   = state_ff.dir[PIN_SELECT] ? level[PIN_SELECT] : 1'b1;  // [R8]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff.bus        <= BUS_IDLE;
      state_ff.ack        <= 1'b0;
      state_ff.rdat       <= 8'h00;
      state_ff.dir        <= DIR_RESET;     // [R3] [R4]
      state_ff.latch      <= LATCH_RESET;
      state_ff.analog_cfg <= ANALOG_RESET;  // [R3] [R4] [R14]
      state_ff.cmp_cfg    <= CMP_RESET;
      state_ff.refout     <= 1'b0;
      state_ff.c1_res     <= 1'b0;
      state_ff.c2_res     <= 1'b0;
      state_ff.mask       <= MASK_RESET;    // [R14]
      state_ff.ss_n       <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_rsp_o.ack                  = state_ff.ack;
  assign wb_rsp_o.dat                  = {24'h000000, state_ff.rdat};
  assign analog_enable_o               = state_ff.mask;
  assign vref_select_o                 = state_ff.analog_cfg[VCFG_LSB +: 2];
  assign comparator_mode_o             = cmp_mode;
  assign comparator_input_switch_o     = state_ff.cmp_cfg[SWITCH_BIT];
  assign comparator_reference_output_o = state_ff.refout;
  assign serial_slave_select_one_n_o   = state_ff.ss_n;

endmodule

// file: testbench/pfag_board.sv
`timescale 1ns/1ps
module pfag_board (
  // Board and pads
  input  wire logic       clk_i,
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] drive_val_i,
  input  wire logic [7:0] pad_out_i,
  input  wire logic [7:0] pad_oe_i,
  output logic      [7:0] pad_level_o
);
  // Unheld pins toggle so a stale level never reads as valid
  logic [7:0] float_ff = 8'h00;
  always_ff @(posedge clk_i) begin
    float_ff <= ~float_ff;
  end
  assign pad_level_o = (pad_oe_i & pad_out_i)
    | (~pad_oe_i & ((drive_en_i & drive_val_i) | (~drive_en_i & float_ff)));
endmodule

// file: testbench/pfag_port_monitor.sv
`timescale 1ns/1ps
module pfag_port_monitor
  import pfag_pkg::*;
(
  // Clock and reset
  input wire logic            clk_i,
  input wire logic            rst_i,
  // Observed ports
  input wire pfag_wb_req_type wb_req_i,
  input wire pfag_wb_rsp_type wb_rsp_o,
  input wire logic [7:0]      pin_oe_o,
  input wire logic [6:0]      analog_enable_o,
  input wire logic [2:0]      comparator_mode_o,
  input wire logic            comparator_reference_output_o,
  input wire logic            serial_slave_select_one_n_o
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       ack;
  logic       rd;
  logic [6:0] ana;
  logic       refo;
  logic [2:0] mode;
  assign ack = wb_rsp_o.ack;
  assign rd = ack && !wb_req_i.we;
  assign ana = analog_enable_o;
  assign refo = comparator_reference_output_o;
  assign mode = comparator_mode_o;
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack too long");
  a_req_gets_ack: assert property (wb_req_i.cyc && wb_req_i.stb && !ack |=> ack)
    else $error("no ack");
  a_reset_pin_state: assert property ($fell(rst_i) |-> ana == 7'h7F && pin_oe_o == 8'h00
    && mode == 3'h7 && serial_slave_select_one_n_o) else $error("bad reset state");
  a_ref_blocks_pin: assert property (refo && $past(refo) |-> !pin_oe_o[5])
    else $error("pin 5 driven under ref out");
  a_cfg_top_zero: assert property (rd && wb_req_i.adr == OFS_ANALOG |-> wb_rsp_o.dat[7:6] == 2'h0)
    else $error("analog cfg top bits set");
  a_analog_reads_zero: assert property (rd && wb_req_i.adr == OFS_LEVEL && $stable(ana)
    && $past(ana, 2) == ana |-> (wb_rsp_o.dat[6:0] & ana) == 7'h00) else $error("analog pin read");
  a_mode_sets_analog: assert property (mode != CM_OFF && $past(mode) != CM_OFF
    |-> ana[6:3] == 4'hF) else $error("comparator pins not analog");
  a_dir_sets_oe: assert property (ack && wb_req_i.we && wb_req_i.adr == OFS_DIRECTION
    && wb_req_i.sel[0] |-> ##2 {pin_oe_o[7:6], pin_oe_o[4:0]}
    == ~{$past(wb_req_i.dat[7:6], 2), $past(wb_req_i.dat[4:0], 2)}) else $error("oe mismatch");
  c_level_read: cover property (rd && wb_req_i.adr == OFS_LEVEL);
  c_ref_out: cover property (refo ##1 refo);
  c_select: cover property (!serial_slave_select_one_n_o);
endmodule
bind pfag_port pfag_port_monitor pfag_port_monitor_i (.*);

// file: testbench/pfag_port_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) check(nm, 8'(ex), 8'(got))
module pfag_port_test
  import pfag_pkg::*;
;
  logic            clk_i = 1'h0;
  logic            rst_i = 1'h1;
  pfag_wb_req_type req = '0;
  pfag_wb_rsp_type rsp;
  logic [7:0]      pin_in;
  logic [7:0]      pin_out;
  logic [7:0]      pin_oe;
  logic [7:0]      brd_en = 8'h00;
  logic [7:0]      brd_val = 8'h00;
  logic            cmp1 = 1'h0;
  logic            cmp2 = 1'h0;
  logic [6:0]      ana;
  logic [1:0]      vref;
  logic [2:0]      mode;
  logic            refo;
  logic            ss_n;
  logic            comparator_input_switch;
  logic [7:0]      rd;
  logic [3:0]      bus_sel = 4'h1;
  int              num_errors = 0;
  int              total_checks = 0;
  pfag_port pfag_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .comparator_one_raw_i(cmp1), .comparator_two_raw_i(cmp2), .analog_enable_o(ana),
    .vref_select_o(vref), .comparator_mode_o(mode), .comparator_input_switch_o(comparator_input_switch),
    .comparator_reference_output_o(refo), .serial_slave_select_one_n_o(ss_n));
  pfag_board pfag_board_i (.clk_i(clk_i), .drive_en_i(brd_en), .drive_val_i(brd_val),
    .pad_out_i(pin_out), .pad_oe_i(pin_oe), .pad_level_o(pin_in));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] ex, input logic [7:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    req <= '{1'h1, 1'h1, w, a, bus_sel, {24'h000000, d}};
    @(posedge clk_i);
    for (n = 0; n < 20 && rsp.ack !== 1'h1; n++) begin
      @(posedge clk_i);
    end
    if (rsp.ack !== 1'h1) begin
      num_errors++;
      $display("[FAIL] bus ack expected 1 seen 0");
      complete_run;
    end else begin
      rd = rsp.dat[7:0];
      req <= '0;
    end
  endtask
  task automatic drive(input logic [7:0] en, input logic [7:0] v, input logic c1, input logic c2);
    @(posedge clk_i);
    brd_en <= en;
    brd_val <= v;
    cmp1 <= c1;
    cmp2 <= c2;
  endtask
  // Outputs land one edge after their register; look just past it
  task automatic look;
    @(posedge clk_i);
    #1;
  endtask
  task automatic rst;
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  task automatic t_reset;
    bus(1'h0, OFS_DIRECTION, 8'h00);
    `CHK("dir", 8'hFF, rd);
    bus(1'h0, OFS_LATCH, 8'h00);
    `CHK("latch", 8'h00, rd);
    bus(1'h0, OFS_LEVEL, 8'h00);
    `CHK("level", 8'h00, rd & 8'h7F);
    bus(1'h0, OFS_COMPARE, 8'h00);
    `CHK("cmp cfg", 8'h07, rd);
    bus(1'h0, 8'h20, 8'h00);
    `CHK("unmapped", 8'h00, rd);
    bus(1'h0, OFS_REFOUT, 8'h00);
    `CHK("refout", 8'h00, rd);
    bus_sel = 4'h0;
    bus(1'h1, OFS_DIRECTION, 8'h00);
    bus_sel = 4'h1;
    bus(1'h0, OFS_DIRECTION, 8'h00);
    `CHK("dir no lane", 8'hFF, rd);
    `CHK("mask", 7'h7F, ana);
    `CHK("oe", 8'h00, pin_oe);
  endtask
  task automatic t_digital;
    drive(8'hFF, 8'h4A, 1'h0, 1'h0);
    bus(1'h1, OFS_ANALOG, 8'h0F);
    bus(1'h1, OFS_DIRECTION, 8'hCF);
    bus(1'h1, OFS_LEVEL, 8'hA5);
    look;
    `CHK("oe cf", 8'h30, pin_oe);
    `CHK("out", 8'h20, pin_out & pin_oe);
    bus(1'h0, OFS_LATCH, 8'h00);
    `CHK("latch rb", 8'hA5, rd);
    bus(1'h0, OFS_LEVEL, 8'h00);
    `CHK("level", 8'h6A, rd);
  endtask
  task automatic t_analog;
    bus(1'h1, OFS_DIRECTION, 8'h00);
    bus(1'h1, OFS_ANALOG, 8'h00);
    look;
    look;
    `CHK("oe all", 8'hFF, pin_oe);
    `CHK("drive", 8'hA5, pin_out);
    bus(1'h1, OFS_DIRECTION, 8'hFF);
    bus(1'h1, OFS_ANALOG, 8'hF6);
    look;
    look;
    bus(1'h0, OFS_LEVEL, 8'h00);
    `CHK("gated", 8'h40, rd);
    bus(1'h0, OFS_ANALOG, 8'h00);
    `CHK("acfg", 8'h36, rd);
    `CHK("vref", 2'h3, vref);
  endtask
  task automatic t_compare;
    bus(1'h1, OFS_ANALOG, 8'h0F);
    bus(1'h1, OFS_DIRECTION, 8'h00);
    bus(1'h1, OFS_LATCH, 8'h00);
    drive(8'hFF, 8'h4A, 1'h1, 1'h0);
    bus(1'h1, OFS_COMPARE, 8'h03);
    look;
    look;
    `CHK("pin2 c1", 1'h1, pin_out[2]);
    `CHK("pin1 c2", 1'h0, pin_out[1]);
    `CHK("cmp mask", 4'hF, ana[6:3]);
    bus(1'h1, OFS_COMPARE, 8'h3D);
    look;
    look;
    `CHK("mode", 3'h5, mode);
    `CHK("cis", 1'h1, comparator_input_switch);
    `CHK("pin1 inv", 1'h1, pin_out[1]);
    `CHK("pin2 latch", 1'h0, pin_out[2]);
    bus(1'h0, OFS_COMPARE, 8'h00);
    `CHK("cmp rd", 8'hBD, rd);
    bus(1'h1, OFS_COMPARE, 8'h07);
  endtask
  task automatic t_refout;
    bus(1'h1, OFS_REFOUT, 8'h01);
    look;
    look;
    `CHK("ref oe", 8'hDF, pin_oe);
    `CHK("ref en", 1'h1, refo);
    bus(1'h1, OFS_DIRECTION, 8'hFF);
    drive(8'hFF, 8'hFF, 1'h0, 1'h0);
    look;
    look;
    bus(1'h0, OFS_LEVEL, 8'h00);
    `CHK("ref in", 8'hDF, rd);
    bus(1'h1, OFS_REFOUT, 8'h00);
  endtask
  task automatic t_select;
    drive(8'hFF, 8'h7F, 1'h0, 1'h0);
    look;
    look;
    look;
    `CHK("ss sel", 1'h0, ss_n);
    bus(1'h1, OFS_DIRECTION, 8'h7F);
    look;
    look;
    `CHK("ss idle", 1'h1, ss_n);
  endtask
  initial begin
    rst;
    t_reset;
    t_digital;
    t_analog;
    t_compare;
    t_refout;
    t_select;
    rst;
    t_reset;
    complete_run;
  end
endmodule
